// ### hw/clk_ctl_pkg.sv
package clk_ctl_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map (byte offsets)
   localparam logic [7:0] REG_BUS_CLOCK_GATE = 8'h2c;
   localparam logic [7:0] REG_LCD_CLOCK_DIVIDER = 8'h40;
   localparam logic [7:0] REG_SERIAL_PORT_CLOCK_DIVIDER = 8'h44;
   localparam logic [7:0] REG_EXT_IRQ_TRIGGER_CONFIG = 8'h80;
   localparam logic [7:0] REG_EXT_IRQ_EDGE_CLEAR = 8'h84;

   ////////////////////////////////////////////////////////////////////////////
   // Field layouts and reset values
   localparam int GATE_RW_WIDTH = 9;
   localparam int GATE_DMA_STOP_BIT = 0;
   localparam logic [8:0] GATE_RESET = 9'h003;
   localparam logic [31:0] GATE_WORD_RESET = 32'h0000_0003;
   localparam logic [31:0] GATE_DMA_MASK = 32'h0000_0001;
   localparam int DIV_WIDTH = 8;
   localparam logic [7:0] DIV_RESET = 8'h00;
   localparam int NUM_IRQ = 7;
   localparam int TRIG_FIELD_WIDTH = 2;
   localparam int TRIG_WIDTH = 14;
   localparam logic [13:0] TRIG_RESET = 14'h0000;
   localparam int TRIG_EDGE_BIT = 1;
   localparam int TRIG_POL_BIT = 0;

   // Trigger field encodings
   typedef enum logic [1:0] {
      TRIG_LOW_LEVEL = 2'h0,
      TRIG_HIGH_LEVEL = 2'h1,
      TRIG_FALL_EDGE = 2'h2,
      TRIG_RISE_EDGE = 2'h3
   } trig_mode_t;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers for the two ends: trigField for the device, the other two for the host
   function automatic trig_mode_t trigField(input logic [13:0] cfg, input int line);
      trigField = trig_mode_t'(cfg[line*TRIG_FIELD_WIDTH +: TRIG_FIELD_WIDTH]);
   endfunction

   // Divider settings must be zero or a single set bit
   function automatic logic divisorLegal(input logic [7:0] v);
      divisorLegal = ((v & (v - 8'h01)) == 8'h00);
   endfunction

   // One bit per line whose trigger field selects an edge
   function automatic logic [6:0] edgeLines(input logic [13:0] cfg);
      logic [6:0] m;
      m = 7'h00;
      for (int i = 0; i < NUM_IRQ; i++) begin
         m[i] = cfg[i*TRIG_FIELD_WIDTH + TRIG_EDGE_BIT];
      end
      edgeLines = m;
   endfunction

endpackage

// ### hw/clk_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none

// Register link between the controller and the party that programs it
interface clk_ctl_if;
   logic regWrite;
   logic regRead;
   logic [7:0] regAddr;
   logic [31:0] regWdata;
   logic [31:0] regRdata;
   logic regRvalid;

   modport device (
      input regWrite,
      input regRead,
      input regAddr,
      input regWdata,
      output regRdata,
      output regRvalid
   );

   modport host (
      output regWrite,
      output regRead,
      output regAddr,
      output regWdata,
      input regRdata,
      input regRvalid
   );
endinterface

`default_nettype wire

// ### hw/clk_divider.sv
`timescale 1ns/1ps
`default_nettype none

module clk_divider
   import clk_ctl_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] divisor,
   output logic clkTick,
   output logic clkLevel
);

   logic [7:0] activeDiv;
   logic [7:0] halfCount;

   ////////////////////////////////////////////////////////////////////////////
   // Half-period counter; a new divisor is only taken at a period boundary,
   // so a reprogram never yields a pulse shorter than one core_clk period
   always_ff @(posedge core_clk) begin
      if (reset) begin
         activeDiv <= DIV_RESET;
         halfCount <= 8'h00;
         clkLevel <= 1'b0;
         clkTick <= 1'b0;
      end else if (activeDiv == 8'h00) begin
         // Bypass: one tick every cycle, full core_clk rate
         clkTick <= 1'b1;
         clkLevel <= 1'b1;
         halfCount <= 8'h00;
         activeDiv <= divisor;
         if (divisor != 8'h00) begin
            clkLevel <= 1'b0;
         end
      end else if (halfCount == activeDiv - 8'h01) begin
         // Each half lasts activeDiv cycles, so a period is twice the setting
         halfCount <= 8'h00;
         clkLevel <= ~clkLevel;
         clkTick <= ~clkLevel;
         if (clkLevel) begin
            activeDiv <= divisor;
         end
      end else begin
         halfCount <= halfCount + 8'h01;
         clkTick <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ### hw/clk_ctl_device.sv
// Functional notes
// - Gate bit 0 set stops DMA clock.
// - Software never clears gate bit 1.
// - Software writes reset value into gate reserved bits.
// - Nonzero LCD setting divides by twice setting.
// - Zero LCD setting passes core clock through.
// - LCD setting only zero or one set bit.
// - Nonzero serial setting divides by twice setting.
// - Zero serial setting passes core clock through.
// - Serial setting only zero or one set bit.
// - Divider upper bits ignore writes, read zero.
// - Seven two-bit trigger fields in bits 13:0.
// - Reset clears all trigger fields, low level.
// - Clear edge latch before enabling edge trigger.
// - Codes: low, high, falling, rising edge.
// - Edge latch holds until clear written; level unaffected.
`timescale 1ns/1ps
`default_nettype none

module clk_ctl_device
   import clk_ctl_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   clk_ctl_if.device link,
   input wire logic [6:0] extIrqPin,
   output logic dmaClkRun,
   output logic lcdClkTick,
   output logic lcdClkLevel,
   output logic serialClkTick,
   output logic serialClkLevel,
   output logic [6:0] extIrqActive
);

   logic [8:0] busClockGate;
   logic [7:0] lcdDivider;
   logic [7:0] serialDivider;
   logic [13:0] trigConfig;
   logic [6:0] pinMeta;
   logic [6:0] pinSync;
   logic [6:0] pinPrev;
   logic [6:0] edgeLatch;
   logic [6:0] clearMask;
   logic [31:0] next_rdata;

   ////////////////////////////////////////////////////////////////////////////
   // Register writes

   // Clock gate; bits above the stored field read as zero
   always_ff @(posedge core_clk) begin
      if (reset) begin
         busClockGate <= GATE_RESET;
      end else if (link.regWrite && link.regAddr == REG_BUS_CLOCK_GATE) begin
         busClockGate <= link.regWdata[GATE_RW_WIDTH-1:0];
      end
   end

   // Divider settings keep only the low byte
   always_ff @(posedge core_clk) begin
      if (reset) begin
         lcdDivider <= DIV_RESET;
         serialDivider <= DIV_RESET;
      end else if (link.regWrite) begin
         if (link.regAddr == REG_LCD_CLOCK_DIVIDER) begin
            lcdDivider <= link.regWdata[DIV_WIDTH-1:0];
         end
         if (link.regAddr == REG_SERIAL_PORT_CLOCK_DIVIDER) begin
            serialDivider <= link.regWdata[DIV_WIDTH-1:0];
         end
      end
   end

   // Trigger configuration, all lines low-level after reset
   always_ff @(posedge core_clk) begin
      if (reset) begin
         trigConfig <= TRIG_RESET;
      end else if (link.regWrite && link.regAddr == REG_EXT_IRQ_TRIGGER_CONFIG) begin
         trigConfig <= link.regWdata[TRIG_WIDTH-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register reads, answered one cycle after the strobe

   always_comb begin
      next_rdata = 32'h0000_0000;
      case (link.regAddr)
         REG_BUS_CLOCK_GATE: next_rdata = {23'h000000, busClockGate};
         REG_LCD_CLOCK_DIVIDER: next_rdata = {24'h000000, lcdDivider};
         REG_SERIAL_PORT_CLOCK_DIVIDER: next_rdata = {24'h000000, serialDivider};
         REG_EXT_IRQ_TRIGGER_CONFIG: next_rdata = {18'h00000, trigConfig};
         default: next_rdata = 32'h0000_0000; // Edge clear is write-only
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         link.regRdata <= 32'h0000_0000;
         link.regRvalid <= 1'b0;
      end else begin
         link.regRvalid <= link.regRead;
         if (link.regRead) begin
            link.regRdata <= next_rdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // DMA clock enable; registered so the downstream gate cell only ever
   // sees a change just after a core_clk rising edge, hence no runt pulse

   always_ff @(posedge core_clk) begin
      if (reset) begin
         dmaClkRun <= 1'b0;
      end else begin
         dmaClkRun <= ~busClockGate[GATE_DMA_STOP_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Peripheral clock dividers

   clk_divider lcdDiv (
      .core_clk(core_clk),
      .reset(reset),
      .divisor(lcdDivider),
      .clkTick(lcdClkTick),
      .clkLevel(lcdClkLevel)
   );

   clk_divider serialDiv (
      .core_clk(core_clk),
      .reset(reset),
      .divisor(serialDivider),
      .clkTick(serialClkTick),
      .clkLevel(serialClkLevel)
   );

   ////////////////////////////////////////////////////////////////////////////
   // External interrupt lines

   // Pins are asynchronous: two flops before any use
   always_ff @(posedge core_clk) begin
      if (reset) begin
         pinMeta <= 7'h00;
         pinSync <= 7'h00;
         pinPrev <= 7'h00;
      end else begin
         pinMeta <= extIrqPin;
         pinSync <= pinMeta;
         pinPrev <= pinSync;
      end
   end

   assign clearMask = (link.regWrite && link.regAddr == REG_EXT_IRQ_EDGE_CLEAR) ?
                      link.regWdata[NUM_IRQ-1:0] : 7'h00;

   // Edge latches; an edge in the clearing cycle wins over the clear
   always_ff @(posedge core_clk) begin
      if (reset) begin
         edgeLatch <= 7'h00;
      end else begin
         for (int i = 0; i < NUM_IRQ; i++) begin
            case (trigField(trigConfig, i))
               TRIG_FALL_EDGE: begin
                  if (pinPrev[i] && !pinSync[i]) begin
                     edgeLatch[i] <= 1'b1;
                  end else if (clearMask[i]) begin
                     edgeLatch[i] <= 1'b0;
                  end
               end
               TRIG_RISE_EDGE: begin
                  if (!pinPrev[i] && pinSync[i]) begin
                     edgeLatch[i] <= 1'b1;
                  end else if (clearMask[i]) begin
                     edgeLatch[i] <= 1'b0;
                  end
               end
               default: begin
                  // Level modes keep the latch but a clear still empties it
                  if (clearMask[i]) begin
                     edgeLatch[i] <= 1'b0;
                  end
               end
            endcase
         end
      end
   end

   // Active state per line; level lines follow the pin, clear has no effect
   always_ff @(posedge core_clk) begin
      if (reset) begin
         extIrqActive <= 7'h00;
      end else begin
         for (int i = 0; i < NUM_IRQ; i++) begin
            case (trigField(trigConfig, i))
               TRIG_LOW_LEVEL: extIrqActive[i] <= ~pinSync[i];
               TRIG_HIGH_LEVEL: extIrqActive[i] <= pinSync[i];
               default: extIrqActive[i] <= edgeLatch[i];
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// ### hw/clk_ctl_host.sv
`timescale 1ns/1ps
`default_nettype none

module clk_ctl_host
   import clk_ctl_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   clk_ctl_if.host link,
   input wire logic cmdValid,
   input wire logic cmdWrite,
   input wire logic [7:0] cmdAddr,
   input wire logic [31:0] cmdData,
   output logic cmdReady,
   output logic cmdError,
   output logic rspValid,
   output logic [31:0] rspData
);

   typedef enum logic [3:0] {
      HOST_IDLE = 4'b0001,
      HOST_PRECLEAR = 4'b0010,
      HOST_ISSUE = 4'b0100,
      HOST_WAIT_READ = 4'b1000
   } host_state_t;

   host_state_t state;
   logic [31:0] heldData;
   logic cmdIsDivider;

   assign cmdIsDivider = (cmdAddr == REG_LCD_CLOCK_DIVIDER) ||
                         (cmdAddr == REG_SERIAL_PORT_CLOCK_DIVIDER);

   ////////////////////////////////////////////////////////////////////////////
   // Command sequencer; each register access is a one-cycle strobe. A
   // trigger write that selects edges is preceded by a clear of those
   // lines, costing one extra cycle; on a line already in an edge mode, an edge in the clearing cycle still wins over the clear

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= HOST_IDLE;
         heldData <= 32'h0000_0000;
         cmdReady <= 1'b0;
         cmdError <= 1'b0;
         rspValid <= 1'b0;
         rspData <= 32'h0000_0000;
         link.regWrite <= 1'b0;
         link.regRead <= 1'b0;
         link.regAddr <= 8'h00;
         link.regWdata <= 32'h0000_0000;
      end else begin
         link.regWrite <= 1'b0;
         link.regRead <= 1'b0;
         cmdError <= 1'b0;
         rspValid <= 1'b0;
         case (state)
            HOST_IDLE: begin
               cmdReady <= 1'b1;
               if (cmdValid && cmdReady) begin
                  cmdReady <= 1'b0;
                  link.regAddr <= cmdAddr;
                  if (!cmdWrite) begin
                     link.regRead <= 1'b1;
                     state <= HOST_WAIT_READ;
                  end else if (cmdIsDivider && !divisorLegal(cmdData[7:0])) begin
                     cmdError <= 1'b1;
                     state <= HOST_ISSUE;
                  end else if (cmdAddr == REG_BUS_CLOCK_GATE) begin
                     // Only the DMA bit is taken from the caller
                     link.regWrite <= 1'b1;
                     link.regWdata <= (cmdData & GATE_DMA_MASK) |
                                      (GATE_WORD_RESET & ~GATE_DMA_MASK);
                     state <= HOST_ISSUE;
                  end else if (cmdAddr == REG_EXT_IRQ_TRIGGER_CONFIG &&
                               edgeLines(cmdData[13:0]) != 7'h00) begin
                     link.regWrite <= 1'b1;
                     link.regAddr <= REG_EXT_IRQ_EDGE_CLEAR;
                     link.regWdata <= {25'h0000000, edgeLines(cmdData[13:0])};
                     heldData <= cmdData;
                     state <= HOST_PRECLEAR;
                  end else begin
                     link.regWrite <= 1'b1;
                     link.regWdata <= cmdData;
                     state <= HOST_ISSUE;
                  end
               end
            end
            HOST_PRECLEAR: begin
               link.regWrite <= 1'b1;
               link.regAddr <= REG_EXT_IRQ_TRIGGER_CONFIG;
               link.regWdata <= heldData;
               state <= HOST_ISSUE;
            end
            HOST_ISSUE: begin
               cmdReady <= 1'b1;
               state <= HOST_IDLE;
            end
            HOST_WAIT_READ: begin
               if (link.regRvalid) begin
                  rspValid <= 1'b1;
                  rspData <= link.regRdata;
                  cmdReady <= 1'b1;
                  state <= HOST_IDLE;
               end
            end
            default: state <= HOST_IDLE;
         endcase
      end
   end

endmodule

`default_nettype wire

// ### tb/clk_ctl_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// Watches the register link and the DMA clock enable between the two ends
module clk_ctl_assertions (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic [31:0] regRdata,
   input wire logic regRvalid,
   input wire logic dmaClkRun
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   ////////////////////////////////////////////////////////////////////////////
   // Gate register and DMA clock
   property p_dma_follow;
      regWrite && regAddr == 8'h2c |-> ##2 dmaClkRun == !$past(regWdata[0], 2);
   endproperty
   a_dma_follow: assert property (p_dma_follow) else $error("DMA run ignores gate bit");

   // A run enable that moves without a gate write would be a stray clock edge
   property p_dma_quiet;
      $changed(dmaClkRun) |-> $past(regWrite, 2) && $past(regAddr, 2) == 8'h2c;
   endproperty
   a_dma_quiet: assert property (p_dma_quiet) else $error("DMA run moved on its own");

   property p_gate_keep;
      regWrite && regAddr == 8'h2c |-> regWdata[1];
   endproperty
   a_gate_keep: assert property (p_gate_keep) else $error("gate bit 1 written low");

   property p_gate_rsvd;
      regWrite && regAddr == 8'h2c |-> regWdata[31:2] == 30'h0;
   endproperty
   a_gate_rsvd: assert property (p_gate_rsvd) else $error("gate reserved bits wrong");

   ////////////////////////////////////////////////////////////////////////////
   // Divider settings: zero or one set bit only; upper bits read as zero
   property p_lcd_legal;
      regWrite && regAddr == 8'h40 |-> (regWdata[7:0] & (regWdata[7:0] - 8'h01)) == 8'h00;
   endproperty
   a_lcd_legal: assert property (p_lcd_legal) else $error("illegal LCD divider sent");

   property p_ser_legal;
      regWrite && regAddr == 8'h44 |-> (regWdata[7:0] & (regWdata[7:0] - 8'h01)) == 8'h00;
   endproperty
   a_ser_legal: assert property (p_ser_legal) else $error("illegal serial divider sent");

   property p_div_upper;
      regRvalid && ($past(regAddr) == 8'h40 || $past(regAddr) == 8'h44)
         |-> regRdata[31:8] == 24'h0;
   endproperty
   a_div_upper: assert property (p_div_upper) else $error("divider upper bits not zero");

   ////////////////////////////////////////////////////////////////////////////
   // Trigger configuration
   property p_trig_upper;
      regRvalid && $past(regAddr) == 8'h80 |-> regRdata[31:14] == 18'h0;
   endproperty
   a_trig_upper: assert property (p_trig_upper) else $error("trigger upper bits not zero");

   // Edge fields have their upper bit set; a stale latch must be cleared first
   property p_pre_clear;
      regWrite && regAddr == 8'h80 && (regWdata[13:0] & 14'h2aaa) != 14'h0
         |-> $past(regWrite) && $past(regAddr) == 8'h84;
   endproperty
   a_pre_clear: assert property (p_pre_clear) else $error("edge mode without clear");

   c_dma_stop: cover property (regWrite && regAddr == 8'h2c && regWdata[0]);
   c_edge_cfg: cover property (regWrite && regAddr == 8'h80 && regWdata[1]);
   c_div_read: cover property (regRead && regAddr == 8'h40 ##1 regRvalid);
endmodule

`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
   import clk_ctl_pkg::*;
;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic cmdValid = 1'b0;
   logic cmdWrite = 1'b0;
   logic [7:0] cmdAddr = 8'h00;
   logic [31:0] cmdData = 32'h0;
   logic [6:0] extIrqPin = 7'h7f;
   logic cmdReady, cmdError, rspValid, dmaClkRun;
   logic [31:0] rspData;
   logic lcdClkTick, lcdClkLevel, serialClkTick, serialClkLevel;
   logic [6:0] extIrqActive, idle;
   logic [13:0] cfg;
   logic [7:0] v, w;
   logic [31:0] rd;
   logic err, sel = 1'b0;
   int miscompares = 0;
   int checked = 0;
   int per, high;
   wire logic tk;
   wire logic lv;

   // Divider under measurement, chosen by sel
   assign tk = sel ? serialClkTick : lcdClkTick;
   assign lv = sel ? serialClkLevel : lcdClkLevel;

   // Core clock, 8 ns period
   always #4 core_clk = ~core_clk;

   ////////////////////////////////////////////////////////////////////////////
   // The two ends joined by the link
   clk_ctl_if link ();
   clk_ctl_device u_clk_ctl_device (.core_clk(core_clk), .reset(reset), .link(link.device),
      .extIrqPin(extIrqPin), .dmaClkRun(dmaClkRun), .lcdClkTick(lcdClkTick),
      .lcdClkLevel(lcdClkLevel), .serialClkTick(serialClkTick),
      .serialClkLevel(serialClkLevel), .extIrqActive(extIrqActive));
   clk_ctl_host u_clk_ctl_host (.core_clk(core_clk), .reset(reset), .link(link.host),
      .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData(cmdData),
      .cmdReady(cmdReady), .cmdError(cmdError), .rspValid(rspValid), .rspData(rspData));
   clk_ctl_assertions u_clk_ctl_assertions (.core_clk(core_clk), .reset(reset),
      .regWrite(link.regWrite), .regRead(link.regRead), .regAddr(link.regAddr),
      .regWdata(link.regWdata), .regRdata(link.regRdata), .regRvalid(link.regRvalid),
      .dmaClkRun(dmaClkRun));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One host command; ready is a register, so its negedge value is what the edge sees
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      cmdValid <= 1'b1;
      cmdWrite <= wr;
      cmdAddr <= a;
      cmdData <= d;
      @(negedge core_clk);
      while (cmdReady !== 1'b1 && n < 50) begin
         @(negedge core_clk);
         n++;
      end
      // A host that never becomes ready is a failure, not a silent skip
      if (n >= 50) begin
         miscompares++;
         $display("Error at %0t: command never accepted", $time);
      end
      @(posedge core_clk);
      cmdValid <= 1'b0;
      err = 1'b0;
      rd = 32'h0;
      for (n = 0; n < 8; n++) begin
         @(negedge core_clk);
         if (cmdError === 1'b1) err = 1'b1;
         if (rspValid === 1'b1) rd = rspData;
      end
   endtask

   // Skips two ticks (the period in flight and the next), then counts one full period and its high cycles
   task automatic measure();
      int n;
      repeat (2) begin
         n = 0;
         do begin
            @(negedge core_clk);
            n++;
         end while (tk !== 1'b1 && n < 600);
      end
      per = 0;
      high = 0;
      do begin
         @(negedge core_clk);
         per++;
         if (lv === 1'b1) high++;
      end while (tk !== 1'b1 && per < 600);
   endtask

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      repeat (2) @(negedge core_clk);
      chk({30'h0, lcdClkTick, lcdClkLevel}, 32'h3);
      chk({30'h0, serialClkTick, serialClkLevel}, 32'h3);
      xfer(1'b0, REG_BUS_CLOCK_GATE, 32'h0);
      chk(rd, 32'h3);
      xfer(1'b0, REG_EXT_IRQ_TRIGGER_CONFIG, 32'h0);
      chk(rd, 32'h0);
      chk({25'h0, extIrqActive}, 32'h0);
      xfer(1'b0, 8'h90, 32'h0);
      chk(rd, 32'h0);
      xfer(1'b1, REG_BUS_CLOCK_GATE, 32'h0);
      xfer(1'b0, REG_BUS_CLOCK_GATE, 32'h0);
      chk(rd, 32'h2);
      chk({31'h0, dmaClkRun}, 32'h1);
      xfer(1'b1, REG_BUS_CLOCK_GATE, 32'hffff_ffff);
      xfer(1'b0, REG_BUS_CLOCK_GATE, 32'h0);
      chk(rd, 32'h3);
      chk({31'h0, dmaClkRun}, 32'h0);
      // Every legal setting on both dividers, ending back in bypass
      for (int i = 0; i < 9; i++) begin
         v = (i < 8) ? 8'(1 << i) : 8'h00;
         w = (i < 8) ? 8'(1 << (7 - i)) : 8'h00;
         xfer(1'b1, REG_LCD_CLOCK_DIVIDER, {24'hff_ffff, v});
         xfer(1'b1, REG_SERIAL_PORT_CLOCK_DIVIDER, {24'h0, w});
         xfer(1'b0, REG_LCD_CLOCK_DIVIDER, 32'h0);
         chk(rd, {24'h0, v});
         sel = 1'b0;
         measure();
         chk(32'(per), (v == 8'h0) ? 32'h1 : {23'h0, v, 1'b0});
         chk(32'(high), (v == 8'h0) ? 32'h1 : {24'h0, v});
         sel = 1'b1;
         measure();
         chk(32'(per), (w == 8'h0) ? 32'h1 : {23'h0, w, 1'b0});
         chk(32'(high), (w == 8'h0) ? 32'h1 : {24'h0, w});
      end
      xfer(1'b1, REG_LCD_CLOCK_DIVIDER, 32'h3);
      chk({31'h0, err}, 32'h1);
      xfer(1'b1, REG_SERIAL_PORT_CLOCK_DIVIDER, 32'h5);
      chk({31'h0, err}, 32'h1);
      xfer(1'b0, REG_SERIAL_PORT_CLOCK_DIVIDER, 32'h0);
      chk(rd, 32'h0);
      // Each trigger code on all lines: level follows, edge latches until cleared
      for (int m = 0; m < 4; m++) begin
         cfg = {7{2'(m)}};
         idle = cfg[0] ? 7'h00 : 7'h7f;
         xfer(1'b1, REG_EXT_IRQ_TRIGGER_CONFIG, {18'h0, cfg});
         xfer(1'b0, REG_EXT_IRQ_TRIGGER_CONFIG, 32'h0);
         chk(rd, {18'h0, cfg});
         @(posedge core_clk);
         extIrqPin <= idle;
         xfer(1'b1, REG_EXT_IRQ_EDGE_CLEAR, 32'h7f);
         chk({25'h0, extIrqActive}, 32'h0);
         @(posedge core_clk);
         extIrqPin <= ~idle;
         repeat (6) @(negedge core_clk);
         chk({25'h0, extIrqActive}, 32'h7f);
         @(posedge core_clk);
         extIrqPin <= idle;
         repeat (6) @(negedge core_clk);
         chk({25'h0, extIrqActive}, cfg[1] ? 32'h7f : 32'h0);
         // Clear while the pins are active: level lines must not drop
         @(posedge core_clk);
         extIrqPin <= ~idle;
         repeat (6) @(negedge core_clk);
         xfer(1'b1, REG_EXT_IRQ_EDGE_CLEAR, 32'h7f);
         chk({25'h0, extIrqActive}, cfg[1] ? 32'h0 : 32'h7f);
      end
      complete_run();
   end

   // Watchdog well beyond the few thousand cycles the sequence needs
   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      complete_run();
   end
endmodule

`default_nettype wire
